// ### design/adc_seq_device.sv
// converter end: command decode, setup sequencer, result fifo
//
// Function
// - bits six to three point at setup
// - single shot: ready low, 32 clocks, command
// - first eight clocks clear ready flag
// - zero byte repeats same setup, stays data
// - ones byte exits after 24 more clocks
// - multi mode converts depth plus one setups
// - multi mode conversions ignore command pointer bits
// - multi mode follows programmed setup order
// - ready after last setup, results in order
// - single multi run returns to command
// - host reads fifo before background overwrite
// - ones byte exits after fifo emptied
// - calibration keeps command mode, ready at end
// - code 101 pointer 0101 offset-calibrates setup six
// - one offset and gain per channel
// - host programs configuration before setups
// - host reissues command per single conversion
// - null byte leaves command mode unchanged
// - fifo words leave msb first
// - 16-bit word ends in status byte
// - unipolar straight binary, bipolar two's complement
// - codes saturate at span limits
// - overrange flag on out-of-span input
// - channel indicator holds low two bits of converted channel
`timescale 1ns/10ps
`default_nettype none
`include "adc_seq_regs.svh"
module adc_seq_device
  import adc_seq_pkg::*;
#(
  parameter int unsigned fifo_words  = 16,
  parameter int unsigned channels    = 8,
  parameter bit          status_word = 1'b0
) (
  input  wire logic                    clk,
  input  wire logic                    rst,
  adc_link_if.dev                      link,
  input  wire logic                    multi_setup_select,
  input  wire logic                    loop_select,
  input  wire logic                    wait_for_read_select,
  input  wire logic [3:0]              sequence_depth,
  input  wire logic [15:0][2:0]        setup_channel,
  input  wire logic [15:0]             setup_bipolar,
  output logic                         conv_start,
  output logic [3:0]                   conv_setup,
  output logic [2:0]                   conv_channel,
  output logic                         conv_bipolar,
  input  wire logic                    conv_done,
  input  wire logic signed [25:0]      conv_raw,
  input  wire logic                    conv_osc,
  output logic                         cal_start,
  output logic [3:0]                   cal_setup,
  output logic [2:0]                   cal_code,
  output logic [2:0]                   cal_channel,
  input  wire logic                    cal_done,
  input  wire logic [23:0]             cal_value,
  output logic [channels-1:0][23:0]    channel_offset,
  output logic [channels-1:0][23:0]    channel_gain
);
  // --------------------------------------------------------------------
  // declarations
  // --------------------------------------------------------------------
  logic        sclk_s1, sclk_s2, sclk_s3, sdi_s1, sdi_s2;
  logic        rise;
  port_state_t state;
  logic [4:0]  bit_cnt;
  logic [4:0]  word_cnt;
  logic [4:0]  n_words;
  logic [7:0]  shift_in;
  logic [7:0]  byte_in;
  logic        loop_q, wait_q, exit_q;
  logic        go_q;
  logic [3:0]  go_ptr;
  logic [4:0]  go_cnt;
  logic        seq_run, seq_busy;
  logic [3:0]  seq_idx, seq_wr;
  logic [4:0]  seq_left;
  logic        fin, take, data_ready;
  logic        cal_busy, cal_flag;
  logic        ready_q;
  word_t       fifo [fifo_words];

  // --------------------------------------------------------------------
  // link input synchronisers
  // --------------------------------------------------------------------
  // the third sclk stage only feeds the edge detector
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      {sclk_s1, sclk_s2, sclk_s3} <= 3'h0;
      {sdi_s1, sdi_s2} <= 2'h0;
    end else begin
      sclk_s1 <= link.sclk;
      sclk_s2 <= sclk_s1;
      sclk_s3 <= sclk_s2;
      sdi_s1  <= link.serial_in_line;
      sdi_s2  <= sdi_s1;
    end
  end
  assign rise    = sclk_s2 & ~sclk_s3;
  assign byte_in = {shift_in[6:0], sdi_s2};

  // --------------------------------------------------------------------
  // result coding
  // --------------------------------------------------------------------
  function automatic word_t code_word(input logic signed [25:0] raw,
                                      input logic bip,
                                      input logic [2:0] ch,
                                      input logic osc);
    logic signed [25:0] hi, lo, v;
    logic [7:0]         st;
    hi = status_word ? (bip ? `BIP16_HI : `UNI16_HI)
                     : (bip ? `BIP24_HI : `UNI24_HI);
    lo = bip ? (status_word ? `BIP16_LO : `BIP24_LO) : `UNI_LO;
    v  = (raw > hi) ? hi : ((raw < lo) ? lo : raw);
    st = 8'h00;
    st[`ST_CI_HI:`ST_CI_LO] = ch[1:0];
    st[`ST_OVR] = (raw > hi) || (raw < lo);
    st[`ST_OSC] = osc;
    // low bits of the clamped value are straight or two's complement
    if (status_word)
      code_word = {v[15:0], st};
    else
      code_word = v[23:0];
  endfunction : code_word

  // --------------------------------------------------------------------
  // serial port state machine
  // --------------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state    <= p_cmd;
      bit_cnt  <= 5'h00;
      word_cnt <= 5'h00;
      shift_in <= 8'h00;
      n_words  <= 5'h01;
      loop_q   <= 1'b0;
      wait_q   <= 1'b0;
      exit_q   <= 1'b0;
      go_q     <= 1'b0;
      go_ptr   <= `FIRST_SETUP;
      go_cnt   <= 5'h01;
      take     <= 1'b0;
    end else begin
      go_q <= 1'b0;
      take <= 1'b0;
      unique case (state)
        p_cmd: if (rise) begin
          shift_in <= byte_in;
          bit_cnt  <= bit_cnt + 5'h01;
          if (bit_cnt == 5'(`FLAG_BITS - 1)) begin
            bit_cnt <= 5'h00;
            // null and non-command bytes fall through here
            if (byte_in[`CMD_FLAG_BIT] && !cal_busy &&
                byte_in[`CC_HI:`CC_LO] == `CC_NONE) begin
              go_q   <= 1'b1;
              // pointer ignored, sequence from setup one
              go_ptr <= multi_setup_select ? `FIRST_SETUP
                        : byte_in[`PTR_HI:`PTR_LO];
              go_cnt <= multi_setup_select
                        ? 5'(sequence_depth) + 5'h01 : 5'h01;
              n_words <= multi_setup_select
                        ? 5'(sequence_depth) + 5'h01 : 5'h01;
              loop_q <= loop_select;
              wait_q <= wait_for_read_select;
              state  <= p_wait;
            end
          end
        end
        p_wait: if (data_ready) begin
          take    <= 1'b1;
          bit_cnt <= 5'h00;
          state   <= p_flag;
        end
        p_flag: if (rise) begin
          shift_in <= byte_in;
          bit_cnt  <= bit_cnt + 5'h01;
          if (bit_cnt == 5'(`FLAG_BITS - 1)) begin
            bit_cnt  <= 5'h00;
            word_cnt <= 5'h00;
            // anything but all ones keeps a loop going
            exit_q <= !loop_q || byte_in == `BYTE_ALL_ONES;
            // no-wait loops refill in the background
            if (loop_q && !wait_q && byte_in != `BYTE_ALL_ONES) begin
              go_q   <= 1'b1;
              go_ptr <= go_ptr;
              go_cnt <= n_words;
            end
            state <= p_data;
          end
        end
        p_data: if (rise) begin
          bit_cnt <= bit_cnt + 5'h01;
          if (bit_cnt == 5'(`WORD_BITS - 1)) begin
            bit_cnt  <= 5'h00;
            word_cnt <= word_cnt + 5'h01;
            if (word_cnt == n_words - 5'h01) begin
              // leave only once the whole set is out
              if (exit_q) begin
                state <= p_cmd;
              end else begin
                state <= p_wait;
                if (wait_q) begin
                  go_q   <= 1'b1;
                  go_cnt <= n_words;
                end
              end
            end
          end
        end
      endcase
    end
  end

  // --------------------------------------------------------------------
  // setup sequencer, drives the conversion engine
  // --------------------------------------------------------------------
  assign fin = seq_busy && conv_done && seq_left == 5'h01 && !go_q;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      seq_run      <= 1'b0;
      seq_busy     <= 1'b0;
      seq_idx      <= `FIRST_SETUP;
      seq_wr       <= 4'h0;
      seq_left     <= 5'h00;
      conv_start   <= 1'b0;
      conv_setup   <= `FIRST_SETUP;
      conv_channel <= 3'h0;
      conv_bipolar <= 1'b0;
    end else begin
      conv_start <= 1'b0;
      if (go_q) begin
        seq_run  <= 1'b1;
        seq_busy <= 1'b0;
        seq_idx  <= go_ptr;
        seq_wr   <= 4'h0;
        seq_left <= go_cnt;
      end else if (seq_run && !seq_busy) begin
        conv_start   <= 1'b1;
        conv_setup   <= seq_idx;
        conv_channel <= setup_channel[seq_idx];
        conv_bipolar <= setup_bipolar[seq_idx];
        seq_busy     <= 1'b1;
      end else if (seq_busy && conv_done) begin
        seq_busy <= 1'b0;
        seq_idx  <= seq_idx + 4'h1;
        seq_wr   <= seq_wr + 4'h1;
        seq_left <= seq_left - 5'h01;
        if (seq_left == 5'h01)
          seq_run <= 1'b0;
      end
    end
  end

  // ready flag raised only after the last setup
  // a finish in the same cycle as the take wins
  always_ff @(posedge clk or posedge rst) begin
    if (rst)
      data_ready <= 1'b0;
    else if (fin)
      data_ready <= 1'b1;
    else if (take)
      data_ready <= 1'b0;
  end

  // --------------------------------------------------------------------
  // result fifo, one word per setup in conversion order
  // --------------------------------------------------------------------
  for (genvar i = 0; i < fifo_words; i++) begin : g_fifo
    always_ff @(posedge clk or posedge rst) begin
      if (rst)
        fifo[i] <= '0;
      else if (seq_busy && conv_done && !go_q && 32'(seq_wr) == i)
        fifo[i] <= code_word(conv_raw, conv_bipolar,
                             conv_channel, conv_osc);
    end
  end

  // --------------------------------------------------------------------
  // calibration, one offset and gain store per physical channel
  // --------------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cal_start   <= 1'b0;
      cal_busy    <= 1'b0;
      cal_flag    <= 1'b0;
      cal_setup   <= `FIRST_SETUP;
      cal_code    <= `CC_NONE;
      cal_channel <= 3'h0;
    end else begin
      cal_start <= 1'b0;
      if (state == p_cmd && rise && bit_cnt == 5'(`FLAG_BITS - 1) &&
          byte_in[`CMD_FLAG_BIT] && !cal_busy &&
          byte_in[`CC_HI:`CC_LO] != `CC_NONE) begin
        cal_start   <= 1'b1;
        cal_busy    <= 1'b1;
        cal_setup   <= byte_in[`PTR_HI:`PTR_LO];
        cal_code    <= byte_in[`CC_HI:`CC_LO];
        cal_channel <= setup_channel[byte_in[`PTR_HI:`PTR_LO]];
      end
      if (cal_busy && cal_done) begin
        cal_busy <= 1'b0;
        cal_flag <= 1'b1;
      end else if (state == p_cmd && rise) begin
        cal_flag <= 1'b0;
      end
    end
  end

  // later calibrations of a channel replace earlier ones
  for (genvar c = 0; c < channels; c++) begin : g_cal
    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        channel_offset[c] <= 24'h000000;
        channel_gain[c]   <= 24'h000000;
      end else if (cal_busy && cal_done && 32'(cal_channel) == c) begin
        if (cal_code[`CC_GAIN_BIT])
          channel_gain[c] <= cal_value;
        else
          channel_offset[c] <= cal_value;
      end
    end
  end

  // --------------------------------------------------------------------
  // ready / data line
  // --------------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst)
      ready_q <= 1'b1;
    else
      unique case (state)
        p_cmd:  ready_q <= ~cal_flag;
        p_wait: ready_q <= 1'b1;
        p_flag: ready_q <= 1'b0;
        // msb first, one bit per clock
        p_data: ready_q <= fifo[word_cnt[3:0]][5'(`WORD_BITS - 1) - bit_cnt];
      endcase
  end
  assign link.serial_out_ready_line = ready_q;
endmodule : adc_seq_device
`default_nettype wire

// ### design/adc_seq_regs.svh
// constants of the conversion sequencer serial port
`ifndef ADC_SEQ_REGS_SVH
`define ADC_SEQ_REGS_SVH
// ----------------------------------------------------------------------
// command byte fields
// ----------------------------------------------------------------------
`define CMD_FLAG_BIT   7
`define PTR_HI         6
`define PTR_LO         3
`define CC_HI          2
`define CC_LO          0
`define CC_GAIN_BIT    1
`define CC_NONE        3'h0
// ----------------------------------------------------------------------
// framing
// ----------------------------------------------------------------------
`define FLAG_BITS      8
`define WORD_BITS      24
`define BYTE_ALL_ONES  8'hff
`define FIRST_SETUP    4'h0
// ----------------------------------------------------------------------
// status byte of the 16-bit word
// ----------------------------------------------------------------------
`define ST_CI_HI       7
`define ST_CI_LO       6
`define ST_OVR         1
`define ST_OSC         0
// ----------------------------------------------------------------------
// saturation limits, 26-bit signed
// ----------------------------------------------------------------------
`define UNI24_HI       26'sh0ffffff
`define BIP24_HI       26'sh07fffff
`define BIP24_LO       26'sh3800000
`define UNI16_HI       26'sh000ffff
`define BIP16_HI       26'sh0007fff
`define BIP16_LO       26'sh3ff8000
`define UNI_LO         26'sh0000000
`endif

// ### design/adc_seq_pkg.sv
// types shared by both ends of the sequencer serial port
package adc_seq_pkg;
  typedef logic [23:0] word_t;
  typedef enum logic [2:0] {p_cmd, p_wait, p_flag, p_data} port_state_t;
  typedef enum logic {h_idle, h_run} host_state_t;
endpackage : adc_seq_pkg

// ### design/adc_link_if.sv
// three-wire serial link between host and converter
`timescale 1ns/10ps
`default_nettype none
interface adc_link_if;
  logic sclk;
  logic serial_in_line;
  logic serial_out_ready_line;
  modport dev (input sclk, input serial_in_line,
               output serial_out_ready_line);
  modport host (output sclk, output serial_in_line,
                input serial_out_ready_line);
endinterface : adc_link_if
`default_nettype wire

// ### design/adc_seq_host.sv
// host end: makes the serial clock, sends bytes, reads results
`timescale 1ns/10ps
`default_nettype none
`include "adc_seq_regs.svh"
module adc_seq_host
  import adc_seq_pkg::*;
#(
  parameter int unsigned half = 8
) (
  input  wire logic        clk,
  input  wire logic        rst,
  adc_link_if.host         link,
  input  wire logic        op_valid,
  input  wire logic        op_read,
  input  wire logic [7:0]  op_byte,
  input  wire logic [4:0]  op_words,
  output logic             op_ready,
  output logic             op_done,
  output logic             data_ready,
  output logic [23:0]      rx_word,
  output logic             rx_valid
);
  // --------------------------------------------------------------------
  // declarations
  // --------------------------------------------------------------------
  host_state_t state;
  logic [15:0] div;
  logic [8:0]  bit_idx, bit_total;
  logic [4:0]  wbit;
  logic [7:0]  tx;
  logic [23:0] rx_sh;
  logic        sclk_q, sdi_q, rdy_s1, rdy_s2;

  // ready line passes two stages before use
  always_ff @(posedge clk or posedge rst) begin
    if (rst)
      {rdy_s1, rdy_s2} <= 2'h3;
    else
      {rdy_s1, rdy_s2} <= {link.serial_out_ready_line, rdy_s1};
  end

  // --------------------------------------------------------------------
  // transfer engine; sdi moves on falls, ready line sampled on falls
  // --------------------------------------------------------------------
  // the all-ones or zero byte goes out during the flag clocks
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state     <= h_idle;
      div       <= 16'h0000;
      bit_idx   <= 9'h000;
      bit_total <= 9'h000;
      wbit      <= 5'h00;
      tx        <= 8'h00;
      rx_sh     <= 24'h000000;
      rx_word   <= 24'h000000;
      rx_valid  <= 1'b0;
      op_done   <= 1'b0;
      op_ready  <= 1'b0;
      sclk_q    <= 1'b0;
      sdi_q     <= 1'b0;
    end else begin
      rx_valid <= 1'b0;
      op_done  <= 1'b0;
      unique case (state)
        h_idle: begin
          op_ready <= ~op_valid;
          if (op_valid) begin
            state     <= h_run;
            div       <= 16'h0000;
            bit_idx   <= 9'h000;
            wbit      <= 5'h00;
            tx        <= {op_byte[6:0], 1'b0};
            sdi_q     <= op_byte[7];
            bit_total <= op_read
                         ? 9'(`FLAG_BITS + `WORD_BITS * op_words)
                         : 9'(`FLAG_BITS);
          end
        end
        h_run: begin
          div <= div + 16'h0001;
          if (div == 16'(half - 1)) begin
            div    <= 16'h0000;
            sclk_q <= ~sclk_q;
            if (sclk_q) begin
              bit_idx <= bit_idx + 9'h001;
              sdi_q   <= tx[7];
              tx      <= {tx[6:0], 1'b0};
              // first data bit stands from the 8th rise
              if (bit_idx >= 9'(`FLAG_BITS - 1) &&
                  bit_idx < bit_total - 9'h001) begin
                rx_sh <= {rx_sh[22:0], rdy_s2};
                wbit  <= wbit + 5'h01;
                if (wbit == 5'(`WORD_BITS - 1)) begin
                  wbit     <= 5'h00;
                  rx_word  <= {rx_sh[22:0], rdy_s2};
                  rx_valid <= 1'b1;
                end
              end
              if (bit_idx == bit_total - 9'h001) begin
                state   <= h_idle;
                op_done <= 1'b1;
                sdi_q   <= 1'b0;
              end
            end
          end
        end
      endcase
    end
  end

  // ready line seen low while the clock is idle
  always_ff @(posedge clk or posedge rst) begin
    if (rst)
      data_ready <= 1'b0;
    else
      data_ready <= (state == h_idle) & ~rdy_s2;
  end

  assign link.sclk           = sclk_q;
  assign link.serial_in_line = sdi_q;
endmodule : adc_seq_host
`default_nettype wire

// ### tb/adc_conversion_sequencer_checker.sv
// assertions on the three-wire link between host and converter
`timescale 1ns/10ps
`default_nettype none
module adc_conversion_sequencer_checker (
  input wire logic clk,
  input wire logic rst,
  input wire logic sclk,
  input wire logic serial_in_line,
  input wire logic serial_out_ready_line
);
  // ----------------------------------------------------------------------
  // helper counters
  // ----------------------------------------------------------------------
  logic [5:0] low_cnt;
  logic [9:0] rise_cnt;
  logic       sclk_q;
  // length of the current quiet spell, saturating so it never wraps
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      low_cnt <= 6'h00;
    end else if (sclk) begin
      low_cnt <= 6'h00;
    end else if (low_cnt != 6'h3f) begin
      low_cnt <= low_cnt + 6'h01;
    end
  end
  // clock rises of one burst, cleared once the link has gone quiet
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sclk_q   <= 1'b0;
      rise_cnt <= 10'h000;
    end else begin
      sclk_q <= sclk;
      if (low_cnt == 6'h15) begin
        rise_cnt <= 10'h000;
      end else if (sclk && !sclk_q) begin
        rise_cnt <= rise_cnt + 10'h001;
      end
    end
  end
  // ----------------------------------------------------------------------
  // link properties
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  AST_RST_CLK_IDLE: assert property (
    $fell(rst) |-> !sclk && !serial_in_line)
    else $error("link clock or data not idle after reset");
  AST_RST_READY_HIGH: assert property (
    $fell(rst) |-> serial_out_ready_line)
    else $error("ready line not high after reset");
  AST_CLK_HIGH_SPAN: assert property (
    $rose(sclk) |-> sclk [*8] ##1 !sclk)
    else $error("serial clock high phase not eight cycles");
  AST_CLK_LOW_SPAN: assert property (
    $fell(sclk) |-> !sclk [*8])
    else $error("serial clock low phase too short");
  AST_DATA_ON_LOW: assert property (
    $changed(serial_in_line) |-> !sclk)
    else $error("serial input moved while clock high");
  AST_DATA_HELD_HIGH: assert property (
    $rose(sclk) |=> $stable(serial_in_line) [*7])
    else $error("serial input unstable in high phase");
  AST_READY_HOLDS: assert property (
    $fell(serial_out_ready_line) && low_cnt > 6'h10
      |-> !serial_out_ready_line [*6])
    else $error("ready indication did not hold low");
  AST_BYTES_WHOLE: assert property (
    low_cnt == 6'h14 |-> rise_cnt[2:0] == 3'h0)
    else $error("burst of clocks not a whole number of bytes");
endmodule : adc_conversion_sequencer_checker
`default_nettype wire

// ### tb/adc_conversion_sequencer_tb.sv
// self-checking bench joining the host and converter ends
`timescale 1ns/10ps
`default_nettype none
`include "adc_seq_regs.svh"
module adc_conversion_sequencer_tb
  import adc_seq_pkg::*;
;
  logic clk, rst, op_valid, op_read, op_ready, op_done, data_ready, rx_valid;
  logic [7:0] op_byte;
  logic [4:0] op_words;
  word_t rx_word;
  logic multi_setup_select, loop_select, wait_for_read_select;
  logic [3:0] sequence_depth, conv_setup, cal_setup, exp_cs;
  logic [15:0][2:0] setup_channel;
  logic [15:0] setup_bipolar;
  logic conv_start, conv_bipolar, conv_done, conv_osc, cal_start, cal_done;
  logic [2:0] conv_channel, cal_code, cal_channel, exp_cc, cal_ch;
  logic signed [25:0] conv_raw;
  logic [23:0] cal_value;
  logic [7:0][23:0] channel_offset, channel_gain;
  int miscompares, checks, cycles, n_starts, cnt;
  bit is_cal;
  word_t exp_q[$], got_q[$];
  logic [3:0] set_q[$];
  // ----------------------------------------------------------------------
  // the two ends, the link and its checker
  // ----------------------------------------------------------------------
  adc_link_if u_adc_link_if ();
  adc_seq_device #(.status_word(1'b1)) u_adc_seq_device (
    .clk, .rst, .link(u_adc_link_if), .multi_setup_select, .loop_select,
    .wait_for_read_select, .sequence_depth, .setup_channel, .setup_bipolar,
    .conv_start, .conv_setup, .conv_channel, .conv_bipolar, .conv_done,
    .conv_raw, .conv_osc, .cal_start, .cal_setup, .cal_code, .cal_channel,
    .cal_done, .cal_value, .channel_offset, .channel_gain);
  adc_seq_host #(.half(8)) u_adc_seq_host (
    .clk, .rst, .link(u_adc_link_if), .op_valid, .op_read, .op_byte,
    .op_words, .op_ready, .op_done, .data_ready, .rx_word, .rx_valid);
  adc_conversion_sequencer_checker u_checker (
    .clk, .rst, .sclk(u_adc_link_if.sclk),
    .serial_in_line(u_adc_link_if.serial_in_line),
    .serial_out_ready_line(u_adc_link_if.serial_out_ready_line));
  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  // expected 16-bit word with status byte, clamped at the span limits
  function automatic word_t expw(logic signed [25:0] r, logic b,
                                 logic [2:0] ch, logic o);
    logic signed [25:0] hi, lo, v;
    hi = b ? `BIP16_HI : `UNI16_HI;
    lo = b ? `BIP16_LO : `UNI_LO;
    v = (r > hi) ? hi : (r < lo) ? lo : r;
    return {v[15:0], ch[1:0], 4'h0, (r > hi) || (r < lo), o};
  endfunction : expw
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic tick();
    @(posedge clk);
    #1;
  endtask : tick
  task automatic stop_test();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : stop_test
  // one host operation: hold the request until taken, then await done
  task automatic op(input logic rd, input logic [7:0] b, input logic [4:0] n);
    while (op_ready !== 1'b1) tick();
    {op_read, op_byte, op_words, op_valid} = {rd, b, n, 1'b1};
    while (op_ready !== 1'b0) tick();
    op_valid = 1'b0;
    while (op_done !== 1'b1) tick();
  endtask : op
  task automatic rd(input logic [7:0] fb, input int w);
    while (data_ready !== 1'b1) tick();
    op(1'b1, fb, 5'(w));
    check(got_q.size(), w);
    while (got_q.size() > 0) begin
      check(got_q.pop_front(), exp_q.pop_front());
    end
  endtask : rd
  task automatic run(input logic m, lp, input logic [3:0] d, p, input int sets);
    int w, s0;
    {multi_setup_select, loop_select, sequence_depth} = {m, lp, d};
    w = m ? d + 1 : 1;
    s0 = n_starts;
    repeat (sets * w) set_q.push_back(m ? 4'(set_q.size() % w) : p);
    op(1'b0, {1'b1, m ? 4'($urandom) : p, `CC_NONE}, 5'h0);
    for (int s = 0; s < sets; s++) begin
      rd(s == sets - 1 ? `BYTE_ALL_ONES : 8'h00, w);
    end
    repeat (200) tick();
    check(n_starts - s0, sets * w);
    check(u_adc_link_if.serial_out_ready_line, 1'b1);
  endtask : run
  task automatic cal(input logic [2:0] c, input logic [3:0] p);
    int s0;
    {exp_cc, exp_cs} = {c, p};
    s0 = n_starts;
    op(1'b0, {1'b1, p, c}, 5'h0);
    while (data_ready !== 1'b1) tick();
    check(c[`CC_GAIN_BIT] ? channel_gain[cal_ch] : channel_offset[cal_ch],
          cal_value);
    check(n_starts - s0, 1);
  endtask : cal
  // ----------------------------------------------------------------------
  // processes
  // ----------------------------------------------------------------------
  // stands in for the filter and calibration engine, collects words
  always @(posedge clk) begin
    #1;
    {conv_done, cal_done} = 2'b00;
    if (rx_valid === 1'b1) got_q.push_back(rx_word);
    if (conv_start === 1'b1) begin
      check(conv_setup, set_q.pop_front());
      check({conv_channel, conv_bipolar}, {setup_channel[conv_setup],
            setup_bipolar[conv_setup]});
      check(data_ready, 1'b0);
    end
    if (cal_start === 1'b1) begin
      check({cal_setup, cal_code, cal_channel},
            {exp_cs, exp_cc, setup_channel[exp_cs]});
      cal_ch = cal_channel;
    end
    if (conv_start === 1'b1 || cal_start === 1'b1) begin
      {n_starts, cnt, is_cal} = {n_starts + 1, 32'd40, cal_start};
      if (!wait_for_read_select) cnt = 600;
    end
    if (cnt == 1) begin
      conv_raw = $signed(26'($urandom)) >>> ($urandom % 14);
      {conv_osc, cal_value} = 25'($urandom);
      {cal_done, conv_done} = {is_cal, !is_cal};
      if (!is_cal) exp_q.push_back(expw(conv_raw, conv_bipolar,
                                        conv_channel, conv_osc));
    end
    if (cnt > 0) cnt--;
  end
  // hang guard, well above the length of the whole sequence
  always @(posedge clk) begin
    cycles++;
    if (cycles == 60000) begin
      miscompares++;
      stop_test();
    end
  end
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // main sequence: nulls, single, looped, multi, then calibrations
  initial begin
    void'($urandom(20753));
    {rst, wait_for_read_select} = 2'b11;
    {op_valid, op_read, op_byte, op_words, multi_setup_select} = '0;
    {loop_select, sequence_depth, conv_done, conv_raw, conv_osc} = '0;
    {cal_done, cal_value, cnt} = '0;
    for (int i = 0; i < 16; i++) setup_channel[i] = 3'($urandom);
    setup_channel[7] = setup_channel[5];
    setup_bipolar = 16'($urandom);
    repeat (20) @(posedge clk);
    #1 rst = 1'b0;
    repeat (5) tick();
    repeat (4) op(1'b0, {1'b0, 7'($urandom)}, 5'h0);
    check(n_starts, 0);
    check(u_adc_link_if.serial_out_ready_line, 1'b1);
    run(1'b0, 1'b0, 4'h0, 4'he, 1);
    repeat (3) run(1'b0, 1'b0, 4'h0, 4'($urandom), 1);
    run(1'b0, 1'b1, 4'h0, 4'h3, 3);
    run(1'b1, 1'b0, 4'h5, 4'h0, 1);
    run(1'b1, 1'b0, 4'hf, 4'h0, 1);
    run(1'b1, 1'b1, 4'h2, 4'h0, 2);
    wait_for_read_select = 1'b0;
    run(1'b1, 1'b1, 4'h1, 4'h0, 2);
    cal(3'h5, 4'h5);
    cal(3'h5, 4'h7);
    cal(3'h6, 4'h2);
    stop_test();
  end
endmodule : adc_conversion_sequencer_tb
`default_nettype wire
